// ### hw/vicd_horizontal_filter_select.sv
// Selectable horizontal luma filter with one cycle of latency
`timescale 1ns/100ps
module vicd_horizontal_filter_select #(
   parameter int DW = vicd_pkg::VICD_DW
) (
   input wire logic clock,
   input wire logic resetn,
   input wire vicd_pkg::vicd_filt_t sel,
   input wire logic in_valid,
   input wire logic in_take,
   input wire logic in_line_start,
   input wire logic [DW-1:0] in_y,
   input wire logic [DW-1:0] in_uv,
   output logic out_valid,
   output logic out_take,
   output logic out_line_start,
   output logic [DW-1:0] out_y,
   output logic [DW-1:0] out_uv
);
   import vicd_pkg::*;
   if (DW < 2) begin : g_bad_dw
      $error("vicd_horizontal_filter_select: DW too small");
   end
   logic [DW-1:0] y1_reg, y2_reg, y3_reg;
   wire logic [DW-1:0] h1 = in_line_start ? '0 : y1_reg;
   wire logic [DW-1:0] h2 = in_line_start ? '0 : y2_reg;
   wire logic [DW-1:0] h3 = in_line_start ? '0 : y3_reg;
   wire logic [DW+1:0] sum_pair = {2'b00, in_y} + {2'b00, h1};
   wire logic [DW+1:0] sum_tri = {2'b00, in_y} + {1'b0, h1, 1'b0} + {2'b00, h2};
   wire logic [DW+1:0] sum_quad = sum_pair + {2'b00, h2} + {2'b00, h3};
   logic [DW-1:0] y_next;
   always_comb begin
      unique case (sel)
         VICD_FILT_BYPASS: y_next = in_y;
         VICD_FILT_PAIR: y_next = sum_pair[DW:1];
         VICD_FILT_TRI: y_next = sum_tri[DW+1:2];
         VICD_FILT_QUAD: y_next = sum_quad[DW+1:2];
      endcase
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         y1_reg <= '0;
         y2_reg <= '0;
         y3_reg <= '0;
         out_valid <= 1'b0;
         out_take <= 1'b0;
         out_line_start <= 1'b0;
         out_y <= '0;
         out_uv <= '0;
      end else begin
         out_valid <= in_valid;
         out_take <= in_valid & in_take;
         out_line_start <= in_line_start;
         if (in_valid) begin
            y1_reg <= in_y;
            y2_reg <= h1;
            y3_reg <= h2;
            out_y <= y_next;
            out_uv <= in_uv;
         end else if (in_line_start) begin
            y1_reg <= '0;
            y2_reg <= '0;
            y3_reg <= '0;
         end
      end
   end
   property p_bypass;
      @(posedge clock) disable iff (!resetn)
         (sel == VICD_FILT_BYPASS && in_valid) |=> (out_y == $past(in_y) && out_valid);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass filter altered pixel");
   property p_pair;
      @(posedge clock) disable iff (!resetn)
         (sel == VICD_FILT_PAIR && in_valid && !in_line_start)
            |=> out_y == $past(sum_pair[DW:1]);
   endproperty
   a_pair: assert property (p_pair) else $error("pair filter result wrong");
endmodule // vicd_horizontal_filter_select

// ### hw/vicd_pkg.sv
// Shared constants and types of the video crop and decimate block
package vicd_pkg;
   localparam int VICD_HW = 10;
   localparam int VICD_VW = 10;
   localparam int VICD_DW = 8;
   localparam int VICD_GROUP = 64;
   localparam logic [6:0] VICD_GROUP_W = 7'h40;
   localparam logic [6:0] VICD_ACC_RST = 7'h00;
   localparam logic [5:0] VICD_GRP_LAST = 6'h3F;
   localparam logic [5:0] VICD_GRP_RST = 6'h00;
   localparam logic [7:0] VICD_DATA_RST = 8'h00;
   typedef enum logic [1:0] {
      VICD_FILT_BYPASS,
      VICD_FILT_PAIR,
      VICD_FILT_TRI,
      VICD_FILT_QUAD
   } vicd_filt_t;
endpackage

// ### hw/vicd_top.sv
// Video input window crop, horizontal filter and decimation
`timescale 1ns/100ps
module vicd_top #(
   parameter int HW = vicd_pkg::VICD_HW,
   parameter int VW = vicd_pkg::VICD_VW,
   parameter int DW = vicd_pkg::VICD_DW
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic line_sync,
   input wire logic frame_sync,
   input wire logic pix_valid,
   input wire logic [DW-1:0] pix_y,
   input wire logic [DW-1:0] pix_uv,
   input wire logic line_sync_polarity,
   input wire logic frame_sync_polarity,
   input wire logic [HW-1:0] horizontal_sample_first,
   input wire logic [HW-1:0] horizontal_sample_last,
   input wire logic [VW-1:0] vertical_sample_first,
   input wire logic [VW-1:0] vertical_sample_last,
   input wire logic [5:0] horizontal_drop_count,
   input wire logic [5:0] vertical_drop_count,
   input wire vicd_pkg::vicd_filt_t horizontal_filter_select,
   input wire logic field_display_select,
   input wire logic [HW-1:0] destination_width,
   input wire logic [VW-1:0] destination_height,
   output logic out_valid,
   output logic [DW-1:0] out_y,
   output logic [DW-1:0] out_uv,
   output logic out_line_start,
   output logic out_frame_start,
   output logic [VW:0] out_rect_height,
   output logic config_error
);
   import vicd_pkg::*;
   if (HW < 2 || VW < 2 || DW < 2) begin : g_bad_width
      $error("vicd_top: width parameter too small");
   end

   // Bresenham step: returns keep flag and next accumulator
   function automatic logic [7:0] dec_step(input logic [6:0] acc, input logic [5:0] drop);
      logic [7:0] sum;
      sum = {1'b0, acc} + {1'b0, VICD_GROUP_W - {1'b0, drop}};
      if (sum >= {1'b0, VICD_GROUP_W}) dec_step = {1'b1, 7'(sum - {1'b0, VICD_GROUP_W})};
      else dec_step = {1'b0, sum[6:0]};
   endfunction

   logic line_sync_reg, frame_sync_reg;
   logic [HW-1:0] h_count_reg;
   logic [VW-1:0] v_count_reg;
   logic line_win_reg, line_keep_reg;
   logic [6:0] v_acc_reg, h_acc_reg;
   logic [5:0] h_grp_reg, v_grp_reg;
   logic [6:0] h_kept_reg, v_kept_reg;

   // Active edge detection
   wire logic line_edge = line_sync_polarity ? (line_sync & ~line_sync_reg)
                                             : (~line_sync & line_sync_reg);
   wire logic frame_edge = frame_sync_polarity ? (frame_sync & ~frame_sync_reg)
                                               : (~frame_sync & frame_sync_reg);

   // Horizontal window
   wire logic [HW-1:0] h_idx = line_edge ? '0 : h_count_reg;
   wire logic h_in = (h_idx >= horizontal_sample_first)
                   && (h_idx <= horizontal_sample_last);
   wire logic h_sat = &h_count_reg;

   // Vertical window and line decimation decision at each line edge
   wire logic [VW-1:0] v_idx = frame_edge ? '0 : v_count_reg;
   wire logic v_in = (v_idx >= vertical_sample_first)
                   && (v_idx <= vertical_sample_last);
   wire logic [6:0] v_acc_base = frame_edge ? VICD_ACC_RST : v_acc_reg;
   wire logic [7:0] v_step = dec_step(v_acc_base, vertical_drop_count);
   wire logic v_do_step = line_edge & v_in;
   wire logic line_win_now = line_edge ? v_in : line_win_reg;
   wire logic line_keep_now = line_edge ? v_step[7] : line_keep_reg;
   wire logic win_pix = pix_valid & h_in & line_win_now & line_keep_now;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         line_sync_reg <= 1'b0;
         frame_sync_reg <= 1'b0;
         h_count_reg <= '0;
         v_count_reg <= '0;
         line_win_reg <= 1'b0;
         line_keep_reg <= 1'b0;
         v_acc_reg <= VICD_ACC_RST;
      end else begin
         line_sync_reg <= line_sync;
         frame_sync_reg <= frame_sync;
         if (pix_valid && !(h_sat && !line_edge)) h_count_reg <= h_idx + 1'b1;
         else if (line_edge) h_count_reg <= '0;
         if (line_edge && !(&v_idx)) v_count_reg <= v_idx + 1'b1;
         else if (frame_edge) v_count_reg <= '0;
         line_win_reg <= line_win_now;
         line_keep_reg <= line_keep_now;
         if (v_do_step) v_acc_reg <= v_step[6:0];
         else if (frame_edge) v_acc_reg <= VICD_ACC_RST;
      end
   end

   // Filter ahead of horizontal decimation
   logic f_valid, f_take, f_line_start;
   logic [DW-1:0] f_y, f_uv;
   vicd_horizontal_filter_select #(.DW(DW)) u_filter (
      .clock(clock),
      .resetn(resetn),
      .sel(horizontal_filter_select),
      .in_valid(pix_valid),
      .in_take(win_pix),
      .in_line_start(line_edge),
      .in_y(pix_y),
      .in_uv(pix_uv),
      .out_valid(f_valid),
      .out_take(f_take),
      .out_line_start(f_line_start),
      .out_y(f_y),
      .out_uv(f_uv)
   );

   // Horizontal decimation on the filtered stream
   wire logic [6:0] h_acc_base = f_line_start ? VICD_ACC_RST : h_acc_reg;
   wire logic [7:0] h_step = dec_step(h_acc_base, horizontal_drop_count);
   wire logic h_do_step = f_valid & f_take;

   // Size check and rectangle height
   wire logic [HW:0] h_span = {1'b0, horizontal_sample_last} - {1'b0, horizontal_sample_first}
                              + 1'b1;
   wire logic [VW:0] v_span = {1'b0, vertical_sample_last} - {1'b0, vertical_sample_first}
                              + 1'b1;
   wire logic size_bad = ({1'b0, destination_width} > h_span)
                       || ({1'b0, destination_height} > v_span)
                       || (horizontal_sample_last < horizontal_sample_first)
                       || (vertical_sample_last < vertical_sample_first);
   wire logic [VW:0] rect_next = field_display_select ? {1'b0, destination_height}
                                                     : {destination_height, 1'b0};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         h_acc_reg <= VICD_ACC_RST;
         out_valid <= 1'b0;
         out_y <= VICD_DATA_RST;
         out_uv <= VICD_DATA_RST;
         out_line_start <= 1'b0;
         out_frame_start <= 1'b0;
         out_rect_height <= '0;
         config_error <= 1'b0;
      end else begin
         if (h_do_step) h_acc_reg <= h_step[6:0];
         else if (f_line_start) h_acc_reg <= VICD_ACC_RST;
         out_valid <= h_do_step & h_step[7];
         if (h_do_step && h_step[7]) begin
            out_y <= f_y;
            out_uv <= f_uv;
         end
         out_line_start <= line_edge & v_in & v_step[7];
         out_frame_start <= frame_edge;
         out_rect_height <= rect_next;
         config_error <= size_bad;
      end
   end

   // Checking helpers: group position and kept count
   always_ff @(posedge clock) begin
      if (!resetn) begin
         h_grp_reg <= VICD_GRP_RST;
         h_kept_reg <= VICD_ACC_RST;
         v_grp_reg <= VICD_GRP_RST;
         v_kept_reg <= VICD_ACC_RST;
      end else begin
         if (h_do_step) begin
            h_grp_reg <= (f_line_start ? VICD_GRP_RST : h_grp_reg) + 1'b1;
            h_kept_reg <= (f_line_start || h_grp_reg == VICD_GRP_LAST ? VICD_ACC_RST : h_kept_reg)
                          + {6'h00, h_step[7]};
         end else if (f_line_start) begin
            h_grp_reg <= VICD_GRP_RST;
            h_kept_reg <= VICD_ACC_RST;
         end
         if (v_do_step) begin
            v_grp_reg <= (frame_edge ? VICD_GRP_RST : v_grp_reg) + 1'b1;
            v_kept_reg <= (frame_edge || v_grp_reg == VICD_GRP_LAST ? VICD_ACC_RST : v_kept_reg)
                          + {6'h00, v_step[7]};
         end else if (frame_edge) begin
            v_grp_reg <= VICD_GRP_RST;
            v_kept_reg <= VICD_ACC_RST;
         end
      end
   end

   property p_hwin;
      @(posedge clock) disable iff (!resetn)
         win_pix |-> (h_idx >= horizontal_sample_first && h_idx <= horizontal_sample_last);
   endproperty
   a_hwin: assert property (p_hwin) else $error("pixel taken outside window");
   property p_vwin;
      @(posedge clock) disable iff (!resetn)
         (line_edge && !frame_edge && v_count_reg > vertical_sample_last) |=> !line_win_reg;
   endproperty
   a_vwin: assert property (p_vwin) else $error("line taken below window");
   property p_pol;
      @(posedge clock) disable iff (!resetn)
         (line_sync_polarity && $rose(line_sync)) || (!line_sync_polarity && $fell(line_sync))
            |-> line_edge;
   endproperty
   a_pol: assert property (p_pol) else $error("line edge missed");
   property p_hdrop;
      @(posedge clock) disable iff (!resetn)
         (h_do_step && !f_line_start && h_grp_reg == VICD_GRP_LAST)
            |-> (h_kept_reg + {6'h00, h_step[7]}) == (VICD_GROUP_W - {1'b0, horizontal_drop_count});
   endproperty
   a_hdrop: assert property (p_hdrop) else $error("wrong pixel keep count per group");
   property p_vdrop;
      @(posedge clock) disable iff (!resetn)
         (v_do_step && !frame_edge && v_grp_reg == VICD_GRP_LAST)
            |-> (v_kept_reg + {6'h00, v_step[7]}) == (VICD_GROUP_W - {1'b0, vertical_drop_count});
   endproperty
   a_vdrop: assert property (p_vdrop) else $error("wrong line keep count per group");
   property p_mode;
      @(posedge clock) disable iff (!resetn)
         (!field_display_select && $stable(destination_height)) |=>
            out_rect_height == {$past(destination_height), 1'b0};
   endproperty
   a_mode: assert property (p_mode) else $error("interlace height not doubled");
   property p_size;
      @(posedge clock) disable iff (!resetn)
         ({1'b0, destination_width} > h_span) |=> config_error;
   endproperty
   a_size: assert property (p_size) else $error("oversize window not flagged");
   property p_reload;
      @(posedge clock) disable iff (!resetn)
         (f_line_start && !f_valid) |=> h_acc_reg == VICD_ACC_RST;
   endproperty
   a_reload: assert property (p_reload) else $error("phase not restarted at line");
   property p_out_src;
      @(posedge clock) disable iff (!resetn)
         out_valid |-> $past(f_take);
   endproperty
   a_out_src: assert property (p_out_src) else $error("output pixel not from window");
   c_pixel: cover property (@(posedge clock) disable iff (!resetn) out_valid);
   c_drop: cover property (@(posedge clock) disable iff (!resetn) h_do_step && !h_step[7]);
   c_line_drop: cover property (@(posedge clock) disable iff (!resetn) v_do_step && !v_step[7]);
   c_error: cover property (@(posedge clock) disable iff (!resetn) config_error);
endmodule // vicd_top

// ### verif/vicd_top_tb.sv
// Self-checking bench of the video crop and decimate block
`timescale 1ns/100ps
module vicd_top_tb;
   import vicd_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic start = 1'b0;
   logic lpol = 1'b1;
   logic fpol = 1'b1;
   logic [9:0] hf = 10'h005, hl = 10'h028, vf = 10'h001, vl = 10'h003;
   logic [5:0] hd = 6'h00, vd = 6'h00;
   logic [7:0] np = 8'h30, nl = 8'h05;
   vicd_filt_t sel = VICD_FILT_BYPASS;
   logic mode = 1'b1;
   logic [9:0] dw = 10'h024, dh = 10'h003;
   logic busy, ls, fs, pv, ov, ols, ofs, cerr;
   logic [7:0] py, puv, oy, ouv;
   logic [10:0] orh;
   int errors = 0, samples_checked = 0, cycles = 0, n_pix = 0, n_line = 0, n_frame = 0;
   always #2 clock = ~clock;
   vicd_video_src i_src (.clock(clock), .start(start), .line_pol(lpol), .frame_pol(fpol),
      .lines(nl), .pixels(np), .busy(busy), .line_sync(ls), .frame_sync(fs),
      .pix_valid(pv), .pix_y(py), .pix_uv(puv));
   vicd_top i_dut (.clock(clock), .resetn(resetn), .line_sync(ls), .frame_sync(fs),
      .pix_valid(pv), .pix_y(py), .pix_uv(puv), .line_sync_polarity(lpol),
      .frame_sync_polarity(fpol), .horizontal_sample_first(hf), .horizontal_sample_last(hl),
      .vertical_sample_first(vf), .vertical_sample_last(vl), .horizontal_drop_count(hd),
      .vertical_drop_count(vd), .horizontal_filter_select(sel), .field_display_select(mode),
      .destination_width(dw), .destination_height(dh), .out_valid(ov), .out_y(oy),
      .out_uv(ouv), .out_line_start(ols), .out_frame_start(ofs), .out_rect_height(orh),
      .config_error(cerr));
   always @(posedge clock) begin
      if (ov === 1'b1) n_pix++;
      if (ols === 1'b1) n_line++;
      if (ofs === 1'b1) n_frame++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic int kept(input int n, input int d);
      int acc, k, s;
      acc = 0;
      k = 0;
      for (int i = 0; i < n; i++) begin
         s = acc + 64 - d;
         if (s >= 64) begin
            k++;
            acc = s - 64;
         end else begin
            acc = s;
         end
      end
      return k;
   endfunction
   task automatic frame();
      int n;
      n = 0;
      @(posedge clock);
      #1;
      n_pix = 0;
      n_line = 0;
      n_frame = 0;
      start <= 1'b1;
      @(posedge clock);
      #1;
      start <= 1'b0;
      repeat (3) @(posedge clock);
      while (busy === 1'b1 && n < 8000) begin
         @(posedge clock);
         n++;
      end
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic s_window(input logic pol);
      @(posedge clock);
      lpol <= pol;
      fpol <= pol;
      repeat (3) @(posedge clock);
      frame();
      check(16'(n_pix), 16'h006C);
      check(16'(n_line), 16'h0003);
      check(16'(n_frame), 16'h0001);
   endtask
   task automatic s_group();
      @(posedge clock);
      np <= 8'h50;
      nl <= 8'h45;
      hl <= 10'h048;
      vl <= 10'h042;
      hd <= 6'h0A;
      vd <= 6'h14;
      frame();
      check(16'(n_pix), 16'(kept(68, 10) * kept(66, 20)));
      check(16'(n_line), 16'(kept(66, 20)));
   endtask
   task automatic s_decim();
      int t[4][2] = '{'{10, 0}, '{0, 10}, '{63, 20}, '{32, 63}};
      foreach (t[i]) begin
         @(posedge clock);
         hd <= 6'(t[i][0]);
         vd <= 6'(t[i][1]);
         frame();
         check(16'(n_pix), 16'(kept(36, t[i][0]) * kept(3, t[i][1])));
         check(16'(n_line), 16'(kept(3, t[i][1])));
      end
      @(posedge clock);
      hd <= 6'h00;
      vd <= 6'h00;
   endtask
   task automatic s_filter();
      logic [7:0] e[4] = '{8'h28, 8'h27, 8'h27, 8'h26};
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         sel <= vicd_filt_t'(i);
         frame();
         check(16'(oy), 16'(e[i]));
         check(16'(ouv), 16'h00A8);
      end
   endtask
   task automatic s_config();
      int t[4][5] = '{'{36, 3, 0, 0, 6}, '{36, 3, 1, 0, 3}, '{37, 3, 1, 1, 3}, '{36, 4, 1, 1, 4}};
      foreach (t[i]) begin
         @(posedge clock);
         dw <= 10'(t[i][0]);
         dh <= 10'(t[i][1]);
         mode <= 1'(t[i][2]);
         repeat (3) @(posedge clock);
         #1;
         check(16'(cerr), 16'(t[i][3]));
         check(16'(orh), 16'(t[i][4]));
      end
      @(posedge clock);
      dh <= 10'h003;
      hl <= 10'h003;
      repeat (3) @(posedge clock);
      #1;
      check(16'(cerr), 16'h0001);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      s_window(1'b1);
      s_window(1'b0);
      s_window(1'b1);
      s_decim();
      s_filter();
      s_config();
      s_group();
      test_done();
   end
endmodule // vicd_top_tb

// ### verif/vicd_video_src.sv
// Behavioural video source sending frames of numbered pixels
`timescale 1ns/100ps
module vicd_video_src (
   input wire logic clock,
   input wire logic start,
   input wire logic line_pol,
   input wire logic frame_pol,
   input wire logic [7:0] lines,
   input wire logic [7:0] pixels,
   output logic busy,
   output logic line_sync,
   output logic frame_sync,
   output logic pix_valid,
   output logic [7:0] pix_y,
   output logic [7:0] pix_uv
);
   initial begin
      busy = 1'b0;
      line_sync = 1'b0;
      frame_sync = 1'b0;
      pix_valid = 1'b0;
      pix_y = 8'h00;
      pix_uv = 8'h00;
      forever begin
         @(posedge clock);
         if (start) begin
            busy <= 1'b1;
            for (int l = 0; l < lines; l++) begin
               for (int c = 0; c < pixels + 4; c++) begin
                  line_sync <= (c < 4) ? line_pol : ~line_pol;
                  frame_sync <= (l == 0 && c < 4) ? frame_pol : ~frame_pol;
                  pix_valid <= (c < pixels);
                  pix_y <= (c < pixels) ? 8'(c) : ~pix_y;
                  pix_uv <= (c < pixels) ? 8'(c + 128) : ~pix_uv;
                  @(posedge clock);
               end
            end
            busy <= 1'b0;
         end else begin
            // Idle: syncs inactive, data toggles so no stale pixel shows
            line_sync <= ~line_pol;
            frame_sync <= ~frame_pol;
            pix_valid <= 1'b0;
            pix_y <= ~pix_y;
            pix_uv <= ~pix_uv;
         end
      end
   end
endmodule // vicd_video_src
